// File: design/adc_seq_pkg.sv
// constants shared by the delta-sigma conversion sequencer and decimator
// assumes a 32-bit axi4-lite register bus and one system clock
package adc_seq_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_RATIO = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
   // control field positions
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_MODE_LO = 2;
   localparam int CTRL_RES_LO = 4;
   localparam int CTRL_MUX_LO = 12;
   // status field positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_VALID = 2;
   // interrupt bit positions
   localparam int IRQ_RESULT = 0;
   localparam int IRQ_IGNORED = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam int IRQ_W = 3;
   // values after reset
   localparam logic [4:0] RES_RST = 5'h10;
   localparam logic [3:0] MUX_RST = 4'h0;
   localparam logic [15:0] RATIO_RST = 16'h0020;
   localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
   // resolution limits and turbo threshold
   localparam logic [4:0] RES_MIN = 5'h08;
   localparam logic [4:0] RES_MAX = 5'h14;
   localparam logic [4:0] RES_TURBO_MAX = 5'h10;
   // conversions needed before a result: three priming, one real
   localparam logic [2:0] PRIME_CONV = 3'h4;
   // modulator sample period in clock cycles
   localparam int MOD_DIV_RST = 4;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      MODE_SINGLE,
      MODE_MULTI,
      MODE_CONT,
      MODE_TURBO
   } adc_mode_t;
endpackage

// File: design/dec_if.sv
// signals between sequencer and decimator
// assumes both ends share aclk
`timescale 1ns/1ps
interface dec_if #(parameter int DEC_W = 24);
   logic clear;
   logic mod_bit;
   logic mod_en;
   logic [15:0] ratio;
   logic sample_stb;
   logic [DEC_W-1:0] sample;
   modport dec (input clear, mod_bit, mod_en, ratio,
                output sample_stb, sample);
   modport ctl (output clear, mod_bit, mod_en, ratio,
                input sample_stb, sample);
endinterface

// File: design/sinc4_decim.sv
// fourth-order sinc decimator for a one-bit modulator stream
// assumes mod_bit already synchronised and mod_en a one-cycle strobe
`timescale 1ns/1ps
module sinc4_decim
   import adc_seq_pkg::*;
#(
   parameter int DEC_W = 24
) (
   input wire logic aclk,
   input wire logic aresetn,
   dec_if.dec d
);
   logic [DEC_W-1:0] integ_r [4];
   logic [DEC_W-1:0] dly_r [4];
   logic [DEC_W-1:0] comb [5];
   logic [15:0] cnt_r;
   logic [DEC_W-1:0] in_val;
   logic dec_tick;
   logic [DEC_W-1:0] sample_r;
   logic stb_r;

   assign in_val = {{(DEC_W-1){1'b0}}, d.mod_bit};
   assign dec_tick = d.mod_en && (cnt_r >= d.ratio - 16'h0001);
   // combs run on the last integrator at the decimated rate
   assign comb[0] = integ_r[3];
   for (genvar k = 0; k < 4; k++) begin : g_comb
      assign comb[k+1] = comb[k] - dly_r[k];
   end

   for (genvar k = 0; k < 4; k++) begin : g_stage
      logic [DEC_W-1:0] feed;
      if (k == 0) begin : g_first
         assign feed = in_val;
      end else begin : g_next
         assign feed = integ_r[k-1];
      end
      always_ff @(posedge aclk) begin
         if (!aresetn || d.clear) begin
            integ_r[k] <= '0;
            dly_r[k] <= '0;
         end else begin
            if (d.mod_en) begin
               integ_r[k] <= integ_r[k] + feed;
            end
            if (dec_tick) begin
               dly_r[k] <= comb[k];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || d.clear) begin
         cnt_r <= 16'h0000;
         stb_r <= 1'b0;
         sample_r <= '0;
      end else begin
         stb_r <= dec_tick;
         if (dec_tick) begin
            cnt_r <= 16'h0000;
            sample_r <= comb[4];
         end else if (d.mod_en) begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   assign d.sample_stb = stb_r;
   assign d.sample = sample_r;
endmodule // sinc4_decim

// File: design/adc_seq.sv
// delta-sigma conversion sequencer with axi4-lite registers
// assumes modulator bit and trigger arrive asynchronous to aclk
`timescale 1ns/1ps
module adc_seq
   import adc_seq_pkg::*;
#(
   parameter int DEC_W = 24,
   parameter int MOD_DIV = MOD_DIV_RST
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mod_bit,
   input wire logic conv_trigger,
   output logic conv_done,
   output logic conv_reset,
   output logic [3:0] input_sel,
   output logic irq
);
   typedef enum logic [1:0] {ST_STANDBY, ST_CONV, ST_WAIT} seq_state_t;

   dec_if #(.DEC_W(DEC_W)) dq ();
   sinc4_decim #(.DEC_W(DEC_W)) u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(dq.dec)
   );

   // input synchronisers
   logic [1:0] mod_sync_r;
   logic [2:0] trig_sync_r;
   logic [7:0] div_r;
   logic mod_en_r;
   logic trig_rise;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mod_sync_r <= 2'b00;
         trig_sync_r <= 3'b000;
         div_r <= 8'h00;
         mod_en_r <= 1'b0;
      end else begin
         mod_sync_r <= {mod_sync_r[0], mod_bit};
         trig_sync_r <= {trig_sync_r[1:0], conv_trigger};
         mod_en_r <= (div_r == 8'(MOD_DIV - 1));
         div_r <= (div_r == 8'(MOD_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      end
   end
   assign trig_rise = trig_sync_r[1] & ~trig_sync_r[2];

   // axi write channel
   logic awready_r, wready_r, bvalid_r;
   logic arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire, rd_fire, b_done, r_done, wr_hit;
   logic [31:0] wmask, wbits;
   assign wr_fire = !awready_r && !wready_r && !bvalid_r;
   assign b_done = bvalid_r && s_axi_bready;
   assign rd_fire = s_axi_arvalid && arready_r;
   assign r_done = rvalid_r && s_axi_rready;
   assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                   {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign wbits = wdata_r & wmask;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         waddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            waddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (b_done) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // write decode
   logic wr_ctrl, wr_ratio, wr_istat, wr_imask;
   assign wr_ctrl = wr_fire && waddr_r == OFF_CTRL;
   assign wr_ratio = wr_fire && waddr_r == OFF_RATIO;
   assign wr_istat = wr_fire && waddr_r == OFF_IRQ_STAT;
   assign wr_imask = wr_fire && waddr_r == OFF_IRQ_MASK;
   assign wr_hit = (waddr_r == OFF_CTRL) || (waddr_r == OFF_RATIO) ||
                   (waddr_r == OFF_IRQ_STAT) || (waddr_r == OFF_IRQ_MASK) ||
                   (waddr_r == OFF_STATUS) || (waddr_r == OFF_DATA);

   // configuration registers
   logic [31:0] ctrl_cur, ctrl_new, ratio_new;
   logic [1:0] mode_r;
   logic [4:0] res_r;
   logic [3:0] mux_r;
   logic [15:0] ratio_r;
   logic [IRQ_W-1:0] mask_r;
   logic start_wr, stop_wr, mux_chg;
   assign ctrl_cur = {16'h0000, mux_r, 3'h0, res_r, mode_r, 2'b00};
   assign ctrl_new = (ctrl_cur & ~wmask) | wbits;
   assign ratio_new = ({16'h0000, ratio_r} & ~wmask) | wbits;
   // start bit is a write-one pulse
   assign start_wr = wr_ctrl && wbits[CTRL_START];
   assign stop_wr = wr_ctrl && wbits[CTRL_STOP];
   assign mux_chg = wr_ctrl && ctrl_new[CTRL_MUX_LO +: 4] != mux_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_SINGLE;
         res_r <= RES_RST;
         mux_r <= MUX_RST;
         ratio_r <= RATIO_RST;
         mask_r <= MASK_RST;
      end else begin
         if (wr_ctrl) begin
            mode_r <= ctrl_new[CTRL_MODE_LO +: 2];
            mux_r <= ctrl_new[CTRL_MUX_LO +: 4];
            // resolution kept within 8 to 20 bits
            if (ctrl_new[CTRL_RES_LO +: 5] < RES_MIN) begin
               res_r <= RES_MIN;
            end else if (ctrl_new[CTRL_RES_LO +: 5] > RES_MAX) begin
               res_r <= RES_MAX;
            end else begin
               res_r <= ctrl_new[CTRL_RES_LO +: 5];
            end
         end
         if (wr_ratio) begin
            ratio_r <= (ratio_new[15:0] == 16'h0000) ? 16'h0001 :
                       ratio_new[15:0];
         end
         if (wr_imask) begin
            mask_r <= (mask_r & ~wmask[IRQ_W-1:0]) | wbits[IRQ_W-1:0];
         end
      end
   end

   // sequencer
   seq_state_t state_r, state_nxt;
   logic [2:0] conv_cnt_r, conv_cnt_nxt;
   logic [2:0] mux_cnt_r;
   logic clear_r, clear_nxt;
   logic result_ev, data_read, start_req, is_turbo_hi, reprime;
   logic [DEC_W-1:0] scaled;
   logic [5:0] shift;
   logic done_r, valid_r, busy;
   logic [31:0] data_r;
   logic [IRQ_W-1:0] istat_r, ev;

   assign start_req = start_wr || trig_rise;
   assign busy = state_r != ST_STANDBY;
   assign is_turbo_hi = mode_r == MODE_TURBO && res_r > RES_TURBO_MAX;
   // multi re-primes; turbo only at 16 bits and below
   assign reprime = mode_r == MODE_MULTI ||
                    (mode_r == MODE_TURBO && !is_turbo_hi);
   // fourth conversion since clear is the first result
   assign result_ev = state_r == ST_CONV && dq.sample_stb &&
                      conv_cnt_r == PRIME_CONV - 3'h1;
   assign data_read = rd_fire && s_axi_araddr == OFF_DATA;
   assign shift = 6'(DEC_W) - {1'b0, res_r};
   assign scaled = dq.sample >> shift;

   always_comb begin
      state_nxt = state_r;
      conv_cnt_nxt = conv_cnt_r;
      clear_nxt = 1'b0;
      unique case (state_r)
         ST_STANDBY: begin
            if (start_req) begin
               state_nxt = ST_CONV;
               clear_nxt = 1'b1;
               conv_cnt_nxt = 3'h0;
            end
         end
         ST_CONV: begin
            if (stop_wr) begin
               // converter reset once at the end
               state_nxt = ST_STANDBY;
               clear_nxt = 1'b1;
            end else if (result_ev) begin
               // mode selects what follows a result
               if (mode_r == MODE_SINGLE) begin
                  state_nxt = ST_WAIT;
               end else if (reprime) begin
                  clear_nxt = 1'b1;
                  conv_cnt_nxt = 3'h0;
               end
            end else if (dq.sample_stb) begin
               // priming count saturates in continuous run
               conv_cnt_nxt = conv_cnt_r + 3'h1;
            end
         end
         ST_WAIT: begin
            if (data_read) begin
               state_nxt = ST_STANDBY;
               clear_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_STANDBY;
         conv_cnt_r <= 3'h0;
         clear_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         conv_cnt_r <= conv_cnt_nxt;
         clear_r <= clear_nxt;
      end
   end

   // count samples since the input select changed
   always_ff @(posedge aclk) begin
      if (!aresetn || mux_chg) begin
         mux_cnt_r <= 3'h0;
      end else if (dq.sample_stb && mux_cnt_r != PRIME_CONV) begin
         mux_cnt_r <= mux_cnt_r + 3'h1;
      end
   end

   // done holds until data read, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
         valid_r <= 1'b0;
         data_r <= 32'h0000_0000;
      end else begin
         if (result_ev) begin
            done_r <= 1'b1;
            valid_r <= !mux_chg && mux_cnt_r >= PRIME_CONV - 3'h1;
            data_r <= 32'(scaled[RES_MAX-1:0]);
         end else if (data_read) begin
            done_r <= 1'b0;
         end
      end
   end

   // interrupt events, ignored trigger is counted as an event
   assign ev[IRQ_RESULT] = result_ev;
   assign ev[IRQ_IGNORED] = start_req && busy;
   assign ev[IRQ_OVERRUN] = result_ev && done_r && !data_read;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         istat_r <= '0;
      end else begin
         istat_r <= ev | (istat_r & ~(wr_istat ? wbits[IRQ_W-1:0] : '0));
      end
   end

   // read path
   logic [31:0] rd_mux;
   logic rd_hit;
   assign rd_hit = wr_hit_rd(s_axi_araddr);
   assign rd_mux =
      (s_axi_araddr == OFF_CTRL) ? ctrl_cur :
      (s_axi_araddr == OFF_STATUS) ?
         32'({valid_r, done_r, busy}) :
      (s_axi_araddr == OFF_DATA) ? data_r :
      (s_axi_araddr == OFF_RATIO) ? {16'h0000, ratio_r} :
      (s_axi_araddr == OFF_IRQ_STAT) ? 32'(istat_r) :
      (s_axi_araddr == OFF_IRQ_MASK) ? 32'(mask_r) : 32'h0000_0000;

   function automatic logic wr_hit_rd(input logic [7:0] a);
      wr_hit_rd = a == OFF_CTRL || a == OFF_STATUS || a == OFF_DATA ||
                  a == OFF_RATIO || a == OFF_IRQ_STAT || a == OFF_IRQ_MASK;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else if (rd_fire) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (r_done) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
      end
   end

   // output flops
   logic irq_r, done_out_r;
   logic [3:0] sel_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
         done_out_r <= 1'b0;
         sel_r <= MUX_RST;
      end else begin
         irq_r <= |(istat_r & mask_r);
         done_out_r <= done_r;
         sel_r <= mux_r;
      end
   end

   assign dq.clear = clear_r;
   assign dq.mod_bit = mod_sync_r[1];
   assign dq.mod_en = mod_en_r;
   assign dq.ratio = ratio_r;
   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign conv_done = done_out_r;
   assign conv_reset = clear_r;
   assign input_sel = sel_r;
   assign irq = irq_r;
endmodule // adc_seq

// File: sim/adc_seq_asserts.sv
// port-level property checker for the conversion sequencer
// assumes binding into adc_seq, one clock, sync active-low reset
`timescale 1ns/1ps
module adc_seq_chk
   import adc_seq_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic conv_done,
   input wire logic conv_reset,
   input wire logic [3:0] input_sel
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic rd_hs = s_axi_arvalid && s_axi_arready;
   wire logic data_hs = rd_hs && s_axi_araddr == OFF_DATA;
   property p_done_hold;
      $fell(conv_done) |-> $past(data_hs) || $past(data_hs, 2)
         || $past(data_hs, 3);
   endproperty
   a_done_hold: assert property (p_done_hold)
      else $error("done dropped without a data read");
   property p_prime;
      conv_reset |-> ##3 (!$rose(conv_done)) [*4];
   endproperty
   a_prime: assert property (p_prime)
      else $error("result came too soon after a clear");
   property p_sel;
      $changed(input_sel) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_sel: assert property (p_sel)
      else $error("input select moved without a write");
   property p_rd_lat;
      rd_hs |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("read answer late");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data not held");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response not held");
   property p_unmapped;
      rd_hs && s_axi_araddr == 8'h20 |=>
         s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
endmodule // adc_seq_chk

bind adc_seq adc_seq_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_done, .conv_reset,
   .input_sel);

// File: sim/mod_src.sv
// modulator stand-in: first-order density stream of a fixed level
// assumes the system clock; the level is a parameter
`timescale 1ns/1ps
module mod_src #(parameter logic [7:0] LEVEL = 8'h5a) (
   input wire logic aclk,
   output logic mod_bit
);
   logic [8:0] acc_r = 9'h0;
   always_ff @(posedge aclk) begin
      acc_r <= {1'b0, acc_r[7:0]} + {1'b0, LEVEL};
   end
   assign mod_bit = acc_r[8];
endmodule // mod_src

// File: sim/test_delta_sigma_adc_sequencer.sv
// self-checking bench for the conversion sequencer
// assumes adc_seq with axi4-lite registers and mod_src as modulator
`timescale 1ns/1ps
module test_delta_sigma_adc_sequencer;
   import adc_seq_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig;
   logic awready, wready, bvalid, arready, rvalid, done, creset, irq, mbit;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] strb, sel;
   logic [1:0] bresp, rresp, r;
   int n_mismatch = 0, samples_checked = 0, cyc = 0;
   adc_seq #(.MOD_DIV(2)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .mod_bit(mbit),
      .conv_trigger(trig), .conv_done(done), .conv_reset(creset),
      .input_sel(sel), .irq(irq));
   mod_src u_src (.aclk(aclk), .mod_bit(mbit));
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 10000) begin
         n_mismatch++;
         $display("CHECK FAILED timeout expected 0 seen %0d", cyc);
         results;
      end
   end
   task results;
      $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      strb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw && w));
      idle(2);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      v = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task wdone(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (done !== 1'b1 && n < 2000);
      chk("done", 1, done);
   endtask
   task t_regs;
      rd(OFF_RATIO); chk("ratio", 32'h20, v);
      rd(OFF_CTRL); chk("ctrl", 32'h100, v);
      rd(OFF_IRQ_MASK); chk("mask", 32'h0, v);
      rd(8'h20); chk("rresp", RESP_SLVERR, r);
      wr(8'h20, 32'h1); chk("bresp", RESP_SLVERR, r);
      wr(OFF_RATIO, 32'h4);
      rd(OFF_RATIO); chk("ratio", 32'h4, v);
      $display("test regs done");
   endtask
   task t_single;
      int n;
      wr(OFF_IRQ_MASK, 32'h1);
      wr(OFF_CTRL, 32'h101);
      wdone(n); chk("prime", 1, n >= 28);
      rd(OFF_STATUS); chk("status", 32'h2, v & 32'h2);
      chk("irq", 1, irq);
      rd(OFF_DATA);
      idle(3); chk("done", 0, done);
      idle(200); chk("standby", 0, done);
      wr(OFF_IRQ_MASK, 32'h0);
      idle(2); chk("irq", 0, irq);
      wr(OFF_IRQ_STAT, 32'h7);
      wr(OFF_IRQ_MASK, 32'h7);
      idle(2); chk("irq", 0, irq);
      $display("test single done");
   endtask
   task pulse;
      trig <= 1'b1;
      idle(4);
      trig <= 1'b0;
      idle(4);
   endtask
   task t_trig;
      int n;
      pulse;
      pulse;
      wdone(n); chk("no restart", 1, n < 24);
      rd(OFF_IRQ_STAT); chk("irq stat", 32'h3, v);
      rd(OFF_DATA);
      wr(OFF_IRQ_STAT, 32'h7);
      $display("test trigger done");
   endtask
   task t_modes;
      int n;
      logic [31:0] c [4];
      logic [3:0] f;
      c = '{32'h1105, 32'h2109, 32'h310d, 32'h414d};
      f = 4'b1010;
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CTRL, c[i]); // input select follows any control write, busy or not
         chk("mux", i + 1, sel);
         wdone(n); chk("prime", 1, n >= 28);
         rd(OFF_STATUS); chk("valid", 32'h4, v & 32'h4);
         rd(OFF_DATA);
         wdone(n); chk("interval", f[i], n < 20);
         wr(OFF_CTRL, (c[i] & 32'hfffe) | 32'h2);
         rd(OFF_DATA);
         idle(100); chk("stopped", 0, done);
      end
      $display("test modes done");
   endtask
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      trig = 1'b0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      strb = 4'hf;
      idle(5);
      aresetn <= 1'b1;
      idle(2);
      t_regs;
      t_single;
      t_trig;
      t_modes;
      results;
   end
endmodule // test_delta_sigma_adc_sequencer
